// >>> hdl/spi_eeprom_pin_interface.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module spi_eeprom_pin_interface
#(
    parameter int unsigned ADDR_W       = `ADDR_BITS,
    parameter int unsigned FIFO_DEPTH   = `FIFO_DEPTH,
    parameter int unsigned WRITE_CYCLES = 32'(`WRITE_CYCLE_COUNT)
)
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe,
    output logic      write_busy
);
    eeprom_pkg::pins_t       pins_raw;
    eeprom_pkg::pins_t       pins;
    eeprom_pkg::core_state_t st_reg;
    eeprom_pkg::core_state_t st_next;

    logic [7:0]  mem [0:(1<<ADDR_W)-1];
    logic [7:0]  byte_in;
    logic [7:0]  status_view;
    logic [7:0]  rd_first;
    logic [7:0]  rd_next;
    logic [15:0] full_addr;
    logic        selected;
    logic        paused;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic        wp_fall;
    logic        wp_block;
    logic        wp_block_req;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [7:0]  fifo_in_data;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [7:0]  fifo_out_data;
    logic        pop;

    // Every pin crosses from the master's timing into clk
    assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};

    pin_sync u_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (pins_raw),
        .q       (pins)
    );

    // Write data waits here until select is released (cs_n rises) and the timed cycle drains it
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    function automatic logic in_protected(input logic [15:0] a, input logic [1:0] bp);
        logic hit;
        hit = 1'b1;
        case (bp)
            `BP_NONE:    hit = 1'b0;
            `BP_QUARTER: hit = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            `BP_HALF:    hit = a[ADDR_W-1];
            default:     hit = 1'b1;
        endcase
        return hit;
    endfunction

    assign selected = !pins.cs_n;
    assign paused   = selected && !pins.hold_n;
    assign sck_rise = pins.sck && !st_reg.sck_prev;
    assign sck_fall = !pins.sck && st_reg.sck_prev;
    assign cs_rise  = pins.cs_n && !st_reg.cs_prev;
    assign wp_fall  = !pins.wp_n && st_reg.wp_prev;
    // pin honoured only with enable set
    assign wp_block = !pins.wp_n && st_reg.status[`SR_PPE_BIT];
    assign wp_block_req = wp_fall && st_reg.status[`SR_PPE_BIT];

    assign byte_in   = {st_reg.in_sh[6:0], pins.si};
    assign full_addr = {st_reg.addr[15:8], byte_in};
    assign rd_first  = mem[full_addr[ADDR_W-1:0]];
    assign rd_next   = mem[st_reg.addr[ADDR_W-1:0]];

    always_comb
    begin
        status_view                = st_reg.status;
        status_view[`SR_BUSY_BIT]  = st_reg.busy;
    end

    assign fifo_out_ready = st_reg.busy;
    assign pop            = fifo_out_valid && fifo_out_ready;

    always_comb
    begin
        st_next       = st_reg;
        fifo_in_valid = 1'b0;
        fifo_in_data  = byte_in;

        st_next.sck_prev = pins.sck;
        st_next.wp_prev  = pins.wp_n;
        st_next.cs_prev  = pins.cs_n;

        // self-timed cycle, master clock not needed
        if (st_reg.busy)
        begin
            if (st_reg.wcnt == 32'h0000_0000)
            begin
                st_next.busy                 = 1'b0;
                st_next.array_go             = 1'b0;
                st_next.status_go            = 1'b0;
                st_next.status[`SR_WEL_BIT]  = 1'b0;
                // committed even if the pin fell meanwhile
                if (st_reg.status_go)
                begin
                    st_next.status[`SR_BP_HI_BIT:`SR_BP_LO_BIT] =
                        st_reg.status_pend[`SR_BP_HI_BIT:`SR_BP_LO_BIT];
                    st_next.status[`SR_PPE_BIT] = st_reg.status_pend[`SR_PPE_BIT];
                end
            end
            else
            begin
                st_next.wcnt = st_reg.wcnt - 32'h0000_0001;
            end
        end

        // Page-wrapped drain into the array
        if (pop)
        begin
            st_next.wr_addr[`PAGE_BITS-1:0] = st_reg.wr_addr[`PAGE_BITS-1:0] + 1'b1;
        end

        if (!selected)
        begin
            st_next.phase      = eeprom_pkg::PH_OPCODE;
            st_next.bit_cnt    = 3'h0;
            st_next.out_active = 1'b0;
            st_next.so_oe      = 1'b0;
            if (cs_rise && !st_reg.busy)
            begin
                // aborted or blocked status write dropped
                if (st_reg.status_go && (st_reg.abort || wp_block))
                begin
                    st_next.status_go = 1'b0;
                end
                else if (st_reg.status_go || st_reg.array_go)
                begin
                    st_next.busy = 1'b1;
                    st_next.wcnt = 32'(WRITE_CYCLES - 1);
                end
                st_next.abort = 1'b0;
            end
        end
        else if (paused)
        begin
            // released output, edges ignored, state kept
            st_next.so_oe = 1'b0;
        end
        else
        begin
            st_next.so_oe = st_reg.out_active;
            // pin falling mid-command aborts status write
            if (wp_block_req && (st_reg.status_go ||
                st_reg.phase == eeprom_pkg::PH_STAT_WRITE))
            begin
                st_next.abort = 1'b1;
            end

            if (sck_fall && st_reg.out_active)
            begin
                st_next.so     = st_reg.out_sh[7];
                st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
                st_next.so_oe  = 1'b1;
            end

            if (sck_rise)
            begin
                st_next.in_sh   = byte_in;
                st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                if (st_reg.bit_cnt == `BYTE_LAST)
                begin
                    case (st_reg.phase)
                        eeprom_pkg::PH_OPCODE:
                        begin
                            st_next.opcode = byte_in;
                            st_next.phase  = eeprom_pkg::PH_IGNORE;
                            case (byte_in)
                                `OP_WRITE_ENABLE:
                                begin
                                    if (!st_reg.busy)
                                    begin
                                        st_next.status[`SR_WEL_BIT] = 1'b1;
                                    end
                                end
                                `OP_WRITE_DISABLE:
                                begin
                                    if (!st_reg.busy)
                                    begin
                                        st_next.status[`SR_WEL_BIT] = 1'b0;
                                    end
                                end
                                `OP_READ_STATUS:
                                begin
                                    st_next.out_sh     = status_view;
                                    st_next.out_active = 1'b1;
                                    st_next.phase      = eeprom_pkg::PH_STAT_READ;
                                end
                                `OP_WRITE_STATUS:
                                begin
                                    if (!st_reg.busy && st_reg.status[`SR_WEL_BIT])
                                    begin
                                        st_next.phase = eeprom_pkg::PH_STAT_WRITE;
                                    end
                                end
                                `OP_READ_ARRAY:
                                begin
                                    if (!st_reg.busy)
                                    begin
                                        st_next.phase = eeprom_pkg::PH_ADDR_HI;
                                    end
                                end
                                `OP_WRITE_ARRAY:
                                begin
                                    if (!st_reg.busy && st_reg.status[`SR_WEL_BIT])
                                    begin
                                        st_next.phase = eeprom_pkg::PH_ADDR_HI;
                                    end
                                end
                                default:
                                begin
                                    st_next.phase = eeprom_pkg::PH_IGNORE;
                                end
                            endcase
                        end
                        eeprom_pkg::PH_ADDR_HI:
                        begin
                            st_next.addr[15:8] = byte_in;
                            st_next.phase      = eeprom_pkg::PH_ADDR_LO;
                        end
                        eeprom_pkg::PH_ADDR_LO:
                        begin
                            if (st_reg.opcode == `OP_READ_ARRAY)
                            begin
                                st_next.out_sh     = rd_first;
                                st_next.addr       = full_addr + 16'h0001;
                                st_next.out_active = 1'b1;
                                st_next.phase      = eeprom_pkg::PH_READ;
                            end
                            // protected start address rejects the write
                            else if (in_protected(full_addr,
                                     st_reg.status[`SR_BP_HI_BIT:`SR_BP_LO_BIT]))
                            begin
                                st_next.phase = eeprom_pkg::PH_IGNORE;
                            end
                            else
                            begin
                                st_next.addr    = full_addr;
                                st_next.wr_addr = full_addr;
                                st_next.phase   = eeprom_pkg::PH_WRITE_DATA;
                            end
                        end
                        eeprom_pkg::PH_READ:
                        begin
                            st_next.out_sh = rd_next;
                            st_next.addr   = st_reg.addr + 16'h0001;
                        end
                        eeprom_pkg::PH_STAT_READ:
                        begin
                            st_next.out_sh = status_view;
                        end
                        eeprom_pkg::PH_STAT_WRITE:
                        begin
                            if (!wp_block && !st_reg.abort)
                            begin
                                st_next.status_pend = byte_in;
                                st_next.status_go   = 1'b1;
                            end
                            st_next.phase = eeprom_pkg::PH_IGNORE;
                        end
                        eeprom_pkg::PH_WRITE_DATA:
                        begin
                            // Bytes beyond buffer room are dropped, not wrapped
                            fifo_in_valid = 1'b1;
                            if (fifo_in_ready)
                            begin
                                st_next.array_go = 1'b1;
                            end
                        end
                        default:
                        begin
                            st_next.phase = eeprom_pkg::PH_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg          <= '0;
            st_reg.status   <= `STATUS_RESET;
            st_reg.cs_prev  <= 1'b1;
            st_reg.wp_prev  <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Array contents survive reset like nonvolatile cells
    always_ff @(posedge clk)
    begin
        if (pop)
        begin
            mem[st_reg.wr_addr[ADDR_W-1:0]] <= fifo_out_data;
        end
    end

    assign so         = st_reg.so;
    assign so_oe      = st_reg.so_oe;
    assign write_busy = st_reg.busy;
endmodule

// >>> hdl/eeprom_params.svh
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

`define CLK_FREQ_HZ       64'h0000_0000_0262_5a00
`define WRITE_TIME_MS     64'h0000_0000_0000_0005
`define MS_PER_S          64'h0000_0000_0000_03e8
`define WRITE_CYCLE_COUNT ((`CLK_FREQ_HZ * `WRITE_TIME_MS) / `MS_PER_S)

`define ADDR_BITS         11
`define PAGE_BITS         5
`define FIFO_DEPTH        8
`define BYTE_LAST         3'h7
`define STATUS_RESET      8'h00
`define PINS_IDLE         5'h13

`define SR_BUSY_BIT       0
`define SR_WEL_BIT        1
`define SR_BP_LO_BIT      2
`define SR_BP_HI_BIT      3
`define SR_PPE_BIT        7

`define BP_NONE           2'h0
`define BP_QUARTER        2'h1
`define BP_HALF           2'h2

`define OP_WRITE_ENABLE   8'h0a
`define OP_WRITE_DISABLE  8'h0b
`define OP_READ_STATUS    8'h0c
`define OP_WRITE_STATUS   8'h0d
`define OP_READ_ARRAY     8'h0e
`define OP_WRITE_ARRAY    8'h0f

`endif

// >>> hdl/eeprom_pkg.sv
package eeprom_pkg;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } pins_t;

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        pins_t s3;
        pins_t q;
    } sync_state_t;

    typedef enum logic [2:0] {
        PH_OPCODE,
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_READ,
        PH_STAT_READ,
        PH_STAT_WRITE,
        PH_WRITE_DATA,
        PH_IGNORE
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [2:0]  bit_cnt;
        logic [7:0]  in_sh;
        logic [7:0]  opcode;
        logic [15:0] addr;
        logic [7:0]  out_sh;
        logic        out_active;
        logic        so;
        logic        so_oe;
        logic        sck_prev;
        logic        wp_prev;
        logic        cs_prev;
        logic [7:0]  status;
        logic [7:0]  status_pend;
        logic        status_go;
        logic        array_go;
        logic        abort;
        logic        busy;
        logic [31:0] wcnt;
        logic [15:0] wr_addr;
    } core_state_t;

endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module pin_sync
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire eeprom_pkg::pins_t d,
    output eeprom_pkg::pins_t      q
);
    eeprom_pkg::sync_state_t st_reg;
    eeprom_pkg::sync_state_t st_next;

    // Idle levels keep the pins deselected and unpaused out of reset
    // Clock idles low so the core edge detector sees no false edge
    localparam eeprom_pkg::pins_t PINS_IDLE = `PINS_IDLE;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // Only a level seen by both later stages counts
        for (int i = 0; i < $bits(eeprom_pkg::pins_t); i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= {PINS_IDLE, PINS_IDLE, PINS_IDLE, PINS_IDLE};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;
endmodule

// >>> hdl/byte_fifo.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module byte_fifo
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = `FIFO_DEPTH
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_state_t;

    fifo_state_t      st_reg;
    fifo_state_t      st_next;
    logic [WIDTH-1:0] slots [0:DEPTH-1];
    logic [AW:0]      used;
    logic             push;
    logic             pop;

    // Depth must be a power of two for the wrapping pointers
    assign used      = st_reg.wr - st_reg.rd;
    assign in_ready  = (used != (AW+1)'(DEPTH));
    assign out_valid = (used != '0);
    assign out_data  = slots[st_reg.rd[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop)
        begin
            st_next.rd = st_reg.rd + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
        if (push)
        begin
            slots[st_reg.wr[AW-1:0]] <= in_data;
        end
    end
endmodule

// >>> sim/spi_eeprom_pin_interface_sva.sv
`timescale 1ns/1ps
module spi_eeprom_pin_interface_sva
#(
    parameter int unsigned WRITE_CYCLES = 50
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic write_busy
);
    logic [31:0] busy_cnt_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    always_ff @(posedge clk)
    begin
        if (sys_rst || !write_busy)
            busy_cnt_reg <= 32'h0000_0000;
        else
            busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
    end

    sequence s_deselected;
        cs_n [*6];
    endsequence
    sequence s_paused;
        (!cs_n && !hold_n) [*6];
    endsequence

    a_deselect_release: assert property (s_deselected |-> !so_oe)
        else $error("output driven while deselected");
    a_pause_release: assert property (s_paused |-> !so_oe)
        else $error("output driven while paused");
    a_select_drop: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("output not released after deselect");
    a_oe_needs_select: assert property ($rose(so_oe) |-> !$past(cs_n, 3) && $past(hold_n, 3))
        else $error("output enabled without select");
    a_so_after_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 3))
        else $error("output bit changed away from clock fall");
    a_busy_after_deselect: assert property ($rose(write_busy) |-> $past(cs_n, 3))
        else $error("write cycle started while selected");
    a_busy_length: assert property ($fell(write_busy) |-> busy_cnt_reg >= WRITE_CYCLES - 1)
        else $error("write cycle too short");
    a_busy_bound: assert property (write_busy |-> busy_cnt_reg <= WRITE_CYCLES)
        else $error("write cycle too long");
endmodule

// >>> sim/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model
(
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    input  wire logic so
);
    logic cpol;
    int   pause_at;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        cpol = 1'b0;
        pause_at = -1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic sel();
        sck <= cpol;
        tick(4);
        cs_n <= 1'b0;
        tick(4);
    endtask

    // Released data line must not look valid
    task automatic desel();
        tick(4);
        cs_n <= 1'b1;
        si <= ~si;
        tick(8);
    endtask

    task automatic pause();
        logic held;
        held = si;
        hold_n <= 1'b0;
        tick(4);
        repeat (3)
        begin
            sck <= 1'b1;
            si <= ~si;
            tick(4);
            sck <= 1'b0;
            tick(4);
        end
        // Data bit must be back before the resumed rising edge
        si <= held;
        hold_n <= 1'b1;
        tick(4);
    endtask

    // Sample late in high phase: output moves several clk after the fall
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sck <= 1'b0;
            si <= tx[i];
            tick(4);
            if (7 - i == pause_at)
                pause();
            sck <= 1'b1;
            tick(4);
            rx[i] = so;
        end
        sck <= cpol;
        tick(4);
    endtask
endmodule

// >>> sim/spi_eeprom_pin_interface_tb_top.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module spi_eeprom_pin_interface_tb_top;
    localparam int unsigned WCYC = 50;
    logic       clk;
    logic       sys_rst;
    logic       wp_n;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       hold_n;
    logic       so;
    logic       so_oe;
    logic       write_busy;
    logic       busy_seen;
    logic [7:0] rx;
    logic [7:0] d;
    int         n_mismatch;
    int         tests_run;

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    spi_eeprom_pin_interface #(.WRITE_CYCLES(WCYC)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .so(so), .so_oe(so_oe), .write_busy(write_busy));
    // Released output reads as the inverse so a stale bit cannot pass
    spi_master_model i_master (
        .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so_oe ? so : ~so));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr_done();
        i_master.desel();
        busy_seen = write_busy;
        repeat (WCYC + 10) @(posedge clk);
    endtask

    task automatic wren();
        i_master.sel();
        i_master.xb(`OP_WRITE_ENABLE, d);
        i_master.desel();
    endtask

    task automatic rd_status();
        i_master.sel();
        i_master.xb(`OP_READ_STATUS, d);
        i_master.xb(8'h00, rx);
        i_master.desel();
    endtask

    task automatic wr_array(input logic [7:0] v0, input logic [7:0] v1);
        wren();
        i_master.sel();
        i_master.xb(`OP_WRITE_ARRAY, d);
        i_master.xb(8'h00, d);
        i_master.xb(8'h10, d);
        i_master.xb(v0, d);
        i_master.xb(v1, d);
        wr_done();
    endtask

    task automatic wr_status(input logic [7:0] v);
        wren();
        i_master.sel();
        i_master.xb(`OP_WRITE_STATUS, d);
        i_master.xb(v, d);
    endtask

    task automatic t_array();
        wr_array(8'ha5, 8'h3c);
        chk("array write busy", 8'h01, {7'h00, busy_seen});
        i_master.sel();
        i_master.xb(`OP_READ_ARRAY, d);
        i_master.xb(8'h00, d);
        i_master.xb(8'h10, d);
        i_master.xb(8'h00, rx);
        chk("read byte 0", 8'ha5, rx);
        i_master.xb(8'h00, rx);
        chk("read byte 1", 8'h3c, rx);
        i_master.desel();
    endtask

    task automatic t_protect();
        wr_status(8'h8c);
        wr_done();
        rd_status();
        chk("status set", 8'h8c, rx & 8'h8c);
        wp_n <= 1'b0;
        wr_status(8'h00);
        wr_done();
        chk("blocked write busy", 8'h00, {7'h00, busy_seen});
        rd_status();
        chk("status kept", 8'h8c, rx & 8'h8c);
        wr_array(8'h77, 8'h77);
        chk("protected array busy", 8'h00, {7'h00, busy_seen});
        wp_n <= 1'b1;
        wr_status(8'h00);
        i_master.tick(2);
        wp_n <= 1'b0;
        i_master.tick(8);
        wr_done();
        rd_status();
        chk("aborted write", 8'h8c, rx & 8'h8c);
    endtask

    task automatic t_commit();
        wp_n <= 1'b1;
        wr_status(8'h00);
        i_master.desel();
        wp_n <= 1'b0;
        repeat (WCYC + 10) @(posedge clk);
        rd_status();
        chk("committed write", 8'h00, rx & 8'h8c);
        wr_status(8'h04);
        wr_done();
        rd_status();
        chk("pin ignored", 8'h04, rx & 8'h8c);
        wp_n <= 1'b1;
    endtask

    task automatic t_latch();
        wren();
        rd_status();
        chk("latch set", 8'h02, rx & 8'h02);
        i_master.sel();
        i_master.xb(`OP_WRITE_DISABLE, d);
        i_master.desel();
        rd_status();
        chk("latch cleared", 8'h00, rx & 8'h02);
    endtask

    task automatic t_pause_mode3();
        i_master.pause_at = 4;
        rd_status();
        i_master.pause_at = -1;
        chk("paused read", 8'h04, rx & 8'h8c);
        i_master.cpol = 1'b1;
        rd_status();
        chk("idle high read", 8'h04, rx & 8'h8c);
        i_master.cpol = 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        sys_rst = 1'b1;
        wp_n = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        i_master.sel();
        i_master.desel();
        t_array();
        t_protect();
        t_commit();
        t_latch();
        t_pause_mode3();
        conclude();
    end
endmodule

bind spi_eeprom_pin_interface spi_eeprom_pin_interface_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .write_busy(write_busy));
